//--- verilog/rtc_sched_pkg.sv
package rtc_sched_pkg;
   localparam int NUM_SCHED = 4;
   localparam int SEL_W = 2;
   localparam int FIELD_SLOTS = 8;
   localparam int SUB_PAGES = 4;
   localparam int PARAM_DEPTH = NUM_SCHED * SUB_PAGES * FIELD_SLOTS;
   localparam int PARAM_AW = 7;
   localparam int RTC_FIELDS = 7;

   // bus target addresses of the register pages
   localparam logic [6:0] PAGE_RTC = 7'h6A;
   localparam logic [6:0] PAGE_CTRL = 7'h6B;
   localparam logic [6:0] PAGE_START = 7'h6C;

   // control page offsets
   localparam logic [7:0] OFS_SEL = 8'h16;
   localparam logic [7:0] OFS_RUN = 8'h17;
   localparam logic [7:0] OFS_RTIME = 8'h18;
   localparam logic [7:0] OFS_KIND = 8'h19;
   localparam logic [7:0] OFS_RTIME_HI = 8'h1A;

   // schedule sub-pages, low two bits of the page address
   localparam logic [1:0] SUB_START = 2'h0;
   localparam logic [1:0] SUB_RUNT = 2'h1;
   localparam logic [1:0] SUB_ACT = 2'h2;

   localparam logic [2:0] FLD_ACTIVE = 3'h0;
   localparam logic [2:0] FLD_YEAR = 3'h1;
   localparam logic [2:0] FLD_MONTH = 3'h2;
   localparam logic [2:0] FLD_MDAY = 3'h3;
   localparam logic [2:0] FLD_HOUR = 3'h4;
   localparam logic [2:0] FLD_MINUTE = 3'h5;
   localparam logic [2:0] FLD_DUR_LO = 3'h0;
   localparam logic [2:0] FLD_DUR_HI = 3'h1;
   localparam logic [2:0] FLD_REP = 3'h2;
   localparam logic [2:0] FLD_MULT = 3'h3;
   localparam logic [2:0] FLD_PERIOD = 3'h4;
   localparam logic [2:0] FLD_HOST_PWR = 3'h0;
   localparam logic [2:0] FLD_RELAY = 3'h1;
   localparam logic [2:0] FLD_AUX = 3'h2;

   localparam logic [7:0] RUN_ON = 8'h01;
   localparam logic [7:0] ACTIVE_ON = 8'h01;
   localparam logic [7:0] KIND_BASIC = 8'h00;
   localparam logic [7:0] KIND_CAL = 8'h01;
   localparam logic [7:0] RST_KIND = 8'h00;
   localparam logic [7:0] RST_RUN = 8'h00;
   localparam logic [1:0] RST_SEL = 2'h0;

   localparam logic [15:0] MIN_PER_HOUR = 16'h003C;
   localparam logic [15:0] DAY_MINUTES = 16'h05A0;
   localparam logic [15:0] RTIME_NONE = 16'hFFFF;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEQ} sched_state_t;
endpackage

//--- verilog/param_store.sv
`timescale 1ns/1ps
module param_store #(
   parameter int DEPTH = 128,
   parameter int WIDTH = 8,
   parameter int AW = 7
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o,
   output logic [DEPTH*WIDTH-1:0] contents_o
);
   logic [DEPTH*WIDTH-1:0] mem_q;
   logic [DEPTH*WIDTH-1:0] mem_d;
   logic [WIDTH-1:0] rd_q;
   logic [WIDTH-1:0] rd_d;

   // whole array is visible so every schedule can run at once
   always_comb
   begin
      mem_d = mem_q;
      if (wr_en_i)
      begin
         mem_d[int'(wr_addr_i) * WIDTH +: WIDTH] = wr_data_i;
      end
      rd_d = mem_q[int'(rd_addr_i) * WIDTH +: WIDTH];
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mem_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         mem_q <= mem_d;
         rd_q <= rd_d;
      end
   end

   assign rd_data_o = rd_q;
   assign contents_o = mem_q;
endmodule

//--- verilog/rtc_action_scheduler.sv
`timescale 1ns/1ps
module rtc_action_scheduler #(
   parameter int NUM_SCHED = rtc_sched_pkg::NUM_SCHED
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [6:0] reg_page_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic [7:0] rtc_sec_i,
   input wire logic [7:0] rtc_min_i,
   input wire logic [7:0] rtc_hour_i,
   input wire logic [7:0] rtc_wday_i,
   input wire logic [7:0] rtc_mday_i,
   input wire logic [7:0] rtc_month_i,
   input wire logic [7:0] rtc_year_i,
   input wire logic rtc_minute_tick_i,
   output logic host_power_o,
   output logic relay_set_o,
   output logic aux_power_o,
   output logic sched_running_o
);
   localparam int PBITS = rtc_sched_pkg::PARAM_DEPTH * 8;

   function automatic logic [7:0] pbyte(input logic [PBITS-1:0] p, input int s,
                                        input logic [1:0] sub, input logic [2:0] fld);
      int idx;
      idx = ((s * rtc_sched_pkg::SUB_PAGES + int'(sub)) * rtc_sched_pkg::FIELD_SLOTS
             + int'(fld)) * 8;
      return p[idx +: 8];
   endfunction

   function automatic logic [15:0] bcd_to_bin(input logic [7:0] b);
      return 16'({12'h000, b[7:4]} * 16'h000A + {12'h000, b[3:0]});
   endfunction

   function automatic logic [15:0] day_minute(input logic [7:0] hour_bcd,
                                              input logic [7:0] min_bcd);
      return 16'(bcd_to_bin(hour_bcd) * rtc_sched_pkg::MIN_PER_HOUR + bcd_to_bin(min_bcd));
   endfunction

   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rst_n = rst_sync_q;

   // control registers
   logic [7:0] mirror_q [rtc_sched_pkg::RTC_FIELDS];
   logic [7:0] mirror_d [rtc_sched_pkg::RTC_FIELDS];
   logic [1:0] sel_q, sel_d;
   logic [7:0] run_reg_q, run_reg_d;
   logic [7:0] kind_q, kind_d;
   logic running;
   logic is_param;
   logic param_wr;
   logic [rtc_sched_pkg::PARAM_AW-1:0] param_addr;
   logic [1:0] exec_idx;
   logic exec_found;
   logic [PBITS-1:0] params;
   logic [7:0] store_rdata;

   assign running = (run_reg_q == rtc_sched_pkg::RUN_ON) && (kind_q == rtc_sched_pkg::KIND_CAL);
   assign is_param = reg_page_i[6:2] == rtc_sched_pkg::PAGE_START[6:2];
   assign param_addr = {sel_q, reg_page_i[1:0], reg_addr_i[2:0]};
   // locked while the run flag is up, parameters stay as they were
   assign param_wr = reg_wr_i && is_param && (reg_addr_i[7:3] == 5'h00)
                     && (run_reg_q != rtc_sched_pkg::RUN_ON);

   always_comb
   begin
      // refreshed every cycle, so a host write never sticks
      mirror_d[0] = rtc_sec_i;
      mirror_d[1] = rtc_min_i;
      mirror_d[2] = rtc_hour_i;
      mirror_d[3] = rtc_wday_i;
      mirror_d[4] = rtc_mday_i;
      mirror_d[5] = rtc_month_i;
      mirror_d[6] = rtc_year_i;
      sel_d = sel_q;
      run_reg_d = run_reg_q;
      kind_d = kind_q;
      if (reg_wr_i && reg_page_i == rtc_sched_pkg::PAGE_CTRL)
      begin
         if (reg_addr_i == rtc_sched_pkg::OFS_RUN)
         begin
            run_reg_d = reg_wdata_i;
         end
         if (run_reg_q != rtc_sched_pkg::RUN_ON)
         begin
            if (reg_addr_i == rtc_sched_pkg::OFS_SEL)
            begin
               sel_d = reg_wdata_i[1:0];
            end
            if (reg_addr_i == rtc_sched_pkg::OFS_KIND
                && (reg_wdata_i == rtc_sched_pkg::KIND_BASIC
                    || reg_wdata_i == rtc_sched_pkg::KIND_CAL))
            begin
               kind_d = reg_wdata_i;
            end
         end
      end
      if (running && exec_found)
      begin
         sel_d = exec_idx;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < rtc_sched_pkg::RTC_FIELDS; i++)
         begin
            mirror_q[i] <= 8'h00;
         end
         sel_q <= rtc_sched_pkg::RST_SEL;
         run_reg_q <= rtc_sched_pkg::RST_RUN;
         kind_q <= rtc_sched_pkg::RST_KIND;
      end
      else
      begin
         mirror_q <= mirror_d;
         sel_q <= sel_d;
         run_reg_q <= run_reg_d;
         kind_q <= kind_d;
      end
   end

   // event stamp page is stored for readback and also feeds the schedule engines
   param_store #(
      .DEPTH(rtc_sched_pkg::PARAM_DEPTH),
      .WIDTH(8),
      .AW(rtc_sched_pkg::PARAM_AW)
   ) u_store (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n),
      .wr_en_i(param_wr),
      .wr_addr_i(param_addr),
      .wr_data_i(reg_wdata_i),
      .rd_addr_i(param_addr),
      .rd_data_o(store_rdata),
      .contents_o(params)
   );

   // schedule engines
   rtc_sched_pkg::sched_state_t st_q [NUM_SCHED];
   rtc_sched_pkg::sched_state_t st_d [NUM_SCHED];
   logic on_q [NUM_SCHED];
   logic on_d [NUM_SCHED];
   logic [15:0] on_cnt_q [NUM_SCHED];
   logic [15:0] on_cnt_d [NUM_SCHED];
   logic [7:0] rep_cnt_q [NUM_SCHED];
   logic [7:0] rep_cnt_d [NUM_SCHED];
   logic [7:0] left_q [NUM_SCHED];
   logic [7:0] left_d [NUM_SCHED];
   logic [15:0] seq_cnt_q [NUM_SCHED];
   logic [15:0] seq_cnt_d [NUM_SCHED];
   logic [15:0] rtime_q, rtime_d;
   logic host_q, host_d, relay_q, relay_d, aux_q, aux_d, run_out_q;

   always_comb
   begin
      logic [15:0] dur;
      logic [7:0] rep;
      logic [7:0] mult;
      logic [7:0] period;
      logic date_eq;
      logic do_seq;
      logic do_act;
      logic [15:0] cand;
      logic [15:0] best;
      logic [15:0] start_m;
      logic [15:0] now_m;
      dur = 16'h0000;
      rep = 8'h00;
      mult = 8'h00;
      period = 8'h00;
      date_eq = 1'b0;
      do_seq = 1'b0;
      do_act = 1'b0;
      cand = rtc_sched_pkg::RTIME_NONE;
      best = rtc_sched_pkg::RTIME_NONE;
      now_m = day_minute(rtc_hour_i, rtc_min_i);
      start_m = 16'h0000;
      host_d = 1'b0;
      relay_d = 1'b0;
      aux_d = 1'b0;
      exec_idx = sel_q;
      exec_found = 1'b0;
      for (int s = 0; s < NUM_SCHED; s++)
      begin
         dur = {pbyte(params, s, rtc_sched_pkg::SUB_RUNT, rtc_sched_pkg::FLD_DUR_HI),
                pbyte(params, s, rtc_sched_pkg::SUB_RUNT, rtc_sched_pkg::FLD_DUR_LO)};
         rep = pbyte(params, s, rtc_sched_pkg::SUB_RUNT, rtc_sched_pkg::FLD_REP);
         mult = pbyte(params, s, rtc_sched_pkg::SUB_RUNT, rtc_sched_pkg::FLD_MULT);
         period = pbyte(params, s, rtc_sched_pkg::SUB_RUNT, rtc_sched_pkg::FLD_PERIOD);
         // packed decimal compared digit for digit
         date_eq = rtc_year_i
            == pbyte(params, s, rtc_sched_pkg::SUB_START, rtc_sched_pkg::FLD_YEAR)
            && pbyte(params, s, rtc_sched_pkg::SUB_START, rtc_sched_pkg::FLD_MONTH) == rtc_month_i
            && pbyte(params, s, rtc_sched_pkg::SUB_START, rtc_sched_pkg::FLD_MDAY) == rtc_mday_i;
         start_m = day_minute(pbyte(params, s, rtc_sched_pkg::SUB_START, rtc_sched_pkg::FLD_HOUR),
                              pbyte(params, s, rtc_sched_pkg::SUB_START,
                                    rtc_sched_pkg::FLD_MINUTE));
         st_d[s] = st_q[s];
         on_d[s] = on_q[s];
         on_cnt_d[s] = on_cnt_q[s];
         rep_cnt_d[s] = rep_cnt_q[s];
         left_d[s] = left_q[s];
         seq_cnt_d[s] = seq_cnt_q[s];
         do_seq = 1'b0;
         do_act = 1'b0;
         if (!running)
         begin
            st_d[s] = rtc_sched_pkg::ST_IDLE;
            on_d[s] = 1'b0;
         end
         else
         begin
            unique case (st_q[s])
               rtc_sched_pkg::ST_IDLE:
               begin
                  if (pbyte(params, s, rtc_sched_pkg::SUB_START, rtc_sched_pkg::FLD_ACTIVE)
                      == rtc_sched_pkg::ACTIVE_ON)
                  begin
                     st_d[s] = rtc_sched_pkg::ST_WAIT;
                  end
               end
               rtc_sched_pkg::ST_WAIT:
               begin
                  if (rtc_minute_tick_i && date_eq && start_m == now_m)
                  begin
                     do_seq = 1'b1;
                  end
               end
               rtc_sched_pkg::ST_SEQ:
               begin
                  if (rtc_minute_tick_i)
                  begin
                     if (on_q[s] && on_cnt_q[s] <= 16'h0001)
                     begin
                        on_d[s] = 1'b0;
                     end
                     else if (on_q[s])
                     begin
                        on_cnt_d[s] = on_cnt_q[s] - 16'h0001;
                     end
                     if (rep != 8'h00 && left_q[s] != 8'h00)
                     begin
                        if (rep_cnt_q[s] <= 8'h01)
                        begin
                           do_act = 1'b1;
                        end
                        else
                        begin
                           rep_cnt_d[s] = rep_cnt_q[s] - 8'h01;
                        end
                     end
                     if (period != 8'h00)
                     begin
                        if (seq_cnt_q[s] <= 16'h0001)
                        begin
                           do_seq = 1'b1;
                        end
                        else
                        begin
                           seq_cnt_d[s] = seq_cnt_q[s] - 16'h0001;
                        end
                     end
                  end
               end
            endcase
         end
         // a new occurrence wins over a stop in the same minute
         if (do_seq)
         begin
            st_d[s] = rtc_sched_pkg::ST_SEQ;
            on_d[s] = dur != 16'h0000;
            on_cnt_d[s] = dur;
            rep_cnt_d[s] = rep;
            left_d[s] = (mult == 8'h00) ? 8'h00 : mult - 8'h01;
            seq_cnt_d[s] = 16'({8'h00, period} * rtc_sched_pkg::MIN_PER_HOUR);
         end
         else if (do_act)
         begin
            on_d[s] = dur != 16'h0000;
            on_cnt_d[s] = dur;
            rep_cnt_d[s] = rep;
            left_d[s] = left_q[s] - 8'h01;
         end
         // outputs follow the action bits of each schedule
         if (on_d[s])
         begin
            host_d = host_d | pbyte(params, s, rtc_sched_pkg::SUB_ACT,
                                    rtc_sched_pkg::FLD_HOST_PWR)[0];
            relay_d = relay_d | pbyte(params, s, rtc_sched_pkg::SUB_ACT,
                                      rtc_sched_pkg::FLD_RELAY)[0];
            aux_d = aux_d | pbyte(params, s, rtc_sched_pkg::SUB_ACT, rtc_sched_pkg::FLD_AUX)[0];
         end
         if (!exec_found && st_q[s] == rtc_sched_pkg::ST_SEQ && on_q[s])
         begin
            exec_idx = 2'(s);
            exec_found = 1'b1;
         end
         // distance to the next start or stop of this schedule
         cand = rtc_sched_pkg::RTIME_NONE;
         if (st_q[s] == rtc_sched_pkg::ST_WAIT && date_eq && start_m > now_m)
         begin
            cand = start_m - now_m;
         end
         if (st_q[s] == rtc_sched_pkg::ST_SEQ)
         begin
            if (on_q[s] && on_cnt_q[s] < cand)
            begin
               cand = on_cnt_q[s];
            end
            if (rep != 8'h00 && left_q[s] != 8'h00 && {8'h00, rep_cnt_q[s]} < cand)
            begin
               cand = {8'h00, rep_cnt_q[s]};
            end
            if (period != 8'h00 && seq_cnt_q[s] < cand)
            begin
               cand = seq_cnt_q[s];
            end
         end
         if (cand < best)
         begin
            best = cand;
         end
      end
      rtime_d = (running && best < rtc_sched_pkg::DAY_MINUTES) ? best
                : rtc_sched_pkg::RTIME_NONE;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int s = 0; s < NUM_SCHED; s++)
         begin
            st_q[s] <= rtc_sched_pkg::ST_IDLE;
            on_q[s] <= 1'b0;
            on_cnt_q[s] <= 16'h0000;
            rep_cnt_q[s] <= 8'h00;
            left_q[s] <= 8'h00;
            seq_cnt_q[s] <= 16'h0000;
         end
         rtime_q <= rtc_sched_pkg::RTIME_NONE;
         host_q <= 1'b0;
         relay_q <= 1'b0;
         aux_q <= 1'b0;
         run_out_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         on_q <= on_d;
         on_cnt_q <= on_cnt_d;
         rep_cnt_q <= rep_cnt_d;
         left_q <= left_d;
         seq_cnt_q <= seq_cnt_d;
         rtime_q <= rtime_d;
         host_q <= host_d;
         relay_q <= relay_d;
         aux_q <= aux_d;
         run_out_q <= running;
      end
   end

   // read path: two cycles so parameter and local reads line up
   logic rd1_q, rd1_d, par1_q, par1_d, rvalid_q, rvalid_d;
   logic [7:0] loc1_q, loc1_d, rdata_q, rdata_d;

   always_comb
   begin
      loc1_d = 8'h00;
      if (reg_page_i == rtc_sched_pkg::PAGE_RTC && reg_addr_i < 8'(rtc_sched_pkg::RTC_FIELDS))
      begin
         loc1_d = mirror_q[reg_addr_i[2:0]];
      end
      else if (reg_page_i == rtc_sched_pkg::PAGE_CTRL)
      begin
         unique case (reg_addr_i)
            rtc_sched_pkg::OFS_SEL: loc1_d = {6'h00, sel_q};
            rtc_sched_pkg::OFS_RUN: loc1_d = run_reg_q;
            rtc_sched_pkg::OFS_RTIME: loc1_d = rtime_q[7:0];
            rtc_sched_pkg::OFS_RTIME_HI: loc1_d = rtime_q[15:8];
            rtc_sched_pkg::OFS_KIND: loc1_d = kind_q;
            default: loc1_d = 8'h00;
         endcase
      end
      rd1_d = reg_rd_i;
      par1_d = is_param && (reg_addr_i[7:3] == 5'h00);
      rvalid_d = rd1_q;
      rdata_d = rdata_q;
      if (rd1_q)
      begin
         rdata_d = par1_q ? store_rdata : loc1_q;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd1_q <= 1'b0;
         par1_q <= 1'b0;
         loc1_q <= 8'h00;
         rvalid_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else
      begin
         rd1_q <= rd1_d;
         par1_q <= par1_d;
         loc1_q <= loc1_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign host_power_o = host_q;
   assign relay_set_o = relay_q;
   assign aux_power_o = aux_q;
   assign sched_running_o = run_out_q;
endmodule

//--- test/rtc_action_scheduler_properties.sv
`timescale 1ns/1ps
module rtc_action_scheduler_properties (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [6:0] reg_page_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic reg_rvalid_o,
   input wire logic rtc_minute_tick_i,
   input wire logic host_power_o,
   input wire logic relay_set_o,
   input wire logic aux_power_o,
   input wire logic sched_running_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence read_req;
      reg_rd_i ##1 1'b1;
   endsequence
   sequence run_clear;
      reg_wr_i && reg_page_i == 7'h6B && reg_addr_i == 8'h17 && reg_wdata_i != 8'h01;
   endsequence

   rd_answer_a: assert property (read_req |-> ##1 reg_rvalid_o)
      else $error("read not answered in two cycles");
   rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2))
      else $error("read answer without a read");
   rvalid_single_a: assert property (reg_rvalid_o && !$past(reg_rd_i) |=> !reg_rvalid_o)
      else $error("read answer longer than one cycle");
   run_stop_a: assert property (run_clear |-> ##[1:2] !sched_running_o)
      else $error("scheduler still running after run cleared");
   run_start_a: assert property ($rose(sched_running_o) |->
      $past(reg_wr_i) || $past(reg_wr_i, 2))
      else $error("scheduler started without a write");
   idle_quiet_a: assert property (!sched_running_o [*3] |->
      !host_power_o && !relay_set_o && !aux_power_o)
      else $error("action output on while stopped");
   host_on_a: assert property ($rose(host_power_o) |->
      $past(rtc_minute_tick_i && sched_running_o))
      else $error("host power on off the minute tick");
   relay_on_a: assert property ($rose(relay_set_o) |->
      $past(rtc_minute_tick_i && sched_running_o))
      else $error("relay set off the minute tick");
   aux_on_a: assert property ($rose(aux_power_o) |->
      $past(rtc_minute_tick_i && sched_running_o))
      else $error("aux on off the minute tick");
   host_off_a: assert property ($fell(host_power_o) |->
      $past(rtc_minute_tick_i) || !sched_running_o || !$past(sched_running_o))
      else $error("host power off off the minute tick");
endmodule

bind rtc_action_scheduler rtc_action_scheduler_properties rtc_action_scheduler_properties_i (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_page_i(reg_page_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o), .rtc_minute_tick_i(rtc_minute_tick_i),
   .host_power_o(host_power_o), .relay_set_o(relay_set_o), .aux_power_o(aux_power_o),
   .sched_running_o(sched_running_o)
);

//--- test/host_model.sv
`timescale 1ns/1ps
module host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output logic [6:0] page_o = 7'h00,
   output logic [7:0] addr_o = 8'h00,
   output logic [7:0] wdata_o = 8'h00,
   output logic wr_o = 1'b0,
   output logic rd_o = 1'b0
);
   // one strobe cycle per access, fields held until the strobe drops
   task automatic wr(input logic [6:0] p, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      page_o = p;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      // stale data must not look valid
      wdata_o = ~d;
   endtask

   task automatic rd(input logic [6:0] p, input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      page_o = p;
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      // answer stands one cycle only, the one after the strobe drops
      @(negedge clk_i);
      d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
   endtask
endmodule

//--- test/rtc_action_scheduler_bench.sv
`timescale 1ns/1ps
module rtc_action_scheduler_bench;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic tick = 1'b0;
   logic [7:0] r_min = 8'h59;
   logic [7:0] r_hour = 8'h09;
   logic [7:0] r_sec = 8'h42;
   logic [6:0] page;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, rvalid, host, relay, aux, running;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   always #2 clk_sys_i = ~clk_sys_i;

   rtc_action_scheduler #(.NUM_SCHED(4)) rtc_action_scheduler_i (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_page_i(page), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .rtc_sec_i(r_sec), .rtc_min_i(r_min), .rtc_hour_i(r_hour),
      .rtc_wday_i(8'h01), .rtc_mday_i(8'h20), .rtc_month_i(8'h08), .rtc_year_i(8'h17),
      .rtc_minute_tick_i(tick), .host_power_o(host), .relay_set_o(relay),
      .aux_power_o(aux), .sched_running_o(running)
   );

   host_model host_model_i (
      .clk_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid), .page_o(page), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd)
   );

   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hw(input logic [6:0] p, input logic [7:0] a, input logic [7:0] d);
      host_model_i.wr(p, a, d);
   endtask

   task automatic hr(input logic [6:0] p, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      host_model_i.rd(p, a, v);
      chk(v, e);
   endtask

   // rtc fields move together with the tick, as the clock does
   task automatic tick_min(input logic [7:0] m, input logic [7:0] h);
      @(negedge clk_sys_i);
      r_min = m;
      r_hour = h;
      tick = 1'b1;
      @(negedge clk_sys_i);
      tick = 1'b0;
      @(negedge clk_sys_i);
   endtask

   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end

   task automatic t_reset;
      hr(7'h6B, 8'h19, 8'h00);
      hr(7'h6B, 8'h17, 8'h00);
      hr(7'h6B, 8'h16, 8'h00);
      hr(7'h6B, 8'h18, 8'hFF);
   endtask

   task automatic t_mirror;
      hw(7'h6A, 8'h01, 8'h33);
      hr(7'h6A, 8'h01, 8'h59);
      hr(7'h6A, 8'h06, 8'h17);
      hr(7'h6A, 8'h00, 8'h42);
   endtask

   task automatic t_kind;
      hw(7'h6B, 8'h19, 8'h05);
      hr(7'h6B, 8'h19, 8'h00);
      hw(7'h6B, 8'h19, 8'h01);
      hr(7'h6B, 8'h19, 8'h01);
   endtask

   task automatic prog(input logic [7:0] idx, input logic [7:0] act, input logic [7:0] fld);
      logic [7:0] st [6];
      st = '{act, 8'h17, 8'h08, 8'h20, 8'h10, 8'h00};
      hw(7'h6B, 8'h16, idx);
      for (int i = 0; i < 6; i++)
         hw(7'h6C, i[7:0], st[i]);
      hw(7'h6D, 8'h00, 8'h02);
      hw(7'h6D, 8'h02, 8'h03);
      hw(7'h6D, 8'h03, 8'h02);
      hw(7'h6E, fld, 8'h01);
   endtask

   task automatic t_select;
      prog(8'h00, 8'h00, 8'h01);
      prog(8'h01, 8'h01, 8'h00);
      hw(7'h6E, 8'h02, 8'h01);
      hr(7'h6C, 8'h00, 8'h01);
      hw(7'h6B, 8'h16, 8'h00);
      hr(7'h6C, 8'h00, 8'h00);
      hr(7'h6E, 8'h01, 8'h01);
   endtask

   task automatic t_lock;
      hw(7'h6B, 8'h17, 8'h01);
      hw(7'h6D, 8'h00, 8'h09);
      hw(7'h6B, 8'h16, 8'h03);
      hw(7'h6B, 8'h19, 8'h00);
      hr(7'h6D, 8'h00, 8'h02);
      hr(7'h6B, 8'h16, 8'h00);
      hr(7'h6B, 8'h19, 8'h01);
      hr(7'h6B, 8'h18, 8'h01);
      hr(7'h6B, 8'h1A, 8'h00);
      chk({7'h00, running}, 8'h01);
   endtask

   // schedule 1: on 2 ticks, restart 3 ticks after start, twice; schedule 0 inactive
   task automatic t_sequence;
      logic [6:0] exp;
      exp = 7'h1B;
      for (int i = 0; i < 7; i++)
      begin
         tick_min({4'h0, i[3:0]}, 8'h10);
         chk({7'h00, host}, {7'h00, exp[i]});
         chk({7'h00, relay}, 8'h00);
         chk({7'h00, aux}, {7'h00, exp[i]});
         if (i == 0)
            hr(7'h6B, 8'h16, 8'h01);
      end
      hw(7'h6B, 8'h17, 8'h00);
      hr(7'h6B, 8'h18, 8'hFF);
      chk({7'h00, running}, 8'h00);
      hw(7'h6B, 8'h16, 8'h02);
      hr(7'h6B, 8'h16, 8'h02);
   endtask

   // schedule 0 joins; its sequence restarts one hour after its start
   task automatic t_restart;
      hw(7'h6B, 8'h16, 8'h00);
      hw(7'h6C, 8'h00, 8'h01);
      hw(7'h6D, 8'h04, 8'h01);
      hw(7'h6B, 8'h16, 8'h03);
      hw(7'h6B, 8'h17, 8'h01);
      tick_min(8'h00, 8'h10);
      chk({7'h00, relay}, 8'h01);
      hr(7'h6B, 8'h16, 8'h00);
      repeat (59)
         tick_min(8'h30, 8'h10);
      chk({7'h00, relay}, 8'h00);
      tick_min(8'h31, 8'h10);
      chk({7'h00, relay}, 8'h01);
   endtask

   initial
   begin
      repeat (8) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      t_reset();
      t_mirror();
      t_kind();
      t_select();
      t_lock();
      t_sequence();
      t_restart();
      stop_test();
   end
endmodule
